// ===== hdl/acpc_regs.svh
`ifndef ACPC_REGS_SVH
`define ACPC_REGS_SVH
// Summary of operation
// - Each conversion is timed by the internal clock and ends within 3.5 us.
// - Conversion plus acquisition fits the 200 ksps sample period.
// - A rising edge on the select/convert input starts a conversion.
// - Start edges seen while a conversion runs are ignored.
// - If select/convert is high when a conversion ends, the device naps.
// - In nap only the reference circuits stay powered.
// - If select/convert is low at the end, the MSB goes out and power stays.
// - A set sleep request bit in the serial word puts the device to sleep.
// - After sleep is released the device needs 60 ms before results count.
// - Results are two's complement when bipolar, straight binary otherwise.
// - Select/convert low enables the serial port clocked by the host.

// ============================================================
// Timing
`define ACPC_CLK_MHZ        20
`define ACPC_CYC(ns)        (((ns) * `ACPC_CLK_MHZ) / 1000)
`define ACPC_T_CONV_TYP_NS  3000
`define ACPC_T_CONV_MAX_NS  3500
`define ACPC_T_ACQ_NS       1100
`define ACPC_T_SAMPLE_NS    5000
`define ACPC_T_WAKE_MS      60
`define ACPC_WAKE_CYCLES    (`ACPC_T_WAKE_MS * 1000 * `ACPC_CLK_MHZ)

// ============================================================
// Serial word layout and reset values
`define ACPC_RES_BITS       16
`define ACPC_WORD_BITS      7
`define ACPC_SLEEP_BIT      0
`define ACPC_UNIPOLAR_BIT   1
`define ACPC_RESULT_RST     16'h0000
`define ACPC_WORD_RST       7'h00
`endif

// ===== hdl/acpc_pkg.sv
`default_nettype none
package acpc_pkg;
  typedef enum logic [1:0] {
    PWR_ON    = 2'h0,
    PWR_CONV  = 2'h1,
    PWR_NAP   = 2'h2,
    PWR_SLEEP = 2'h3
  } acpc_pwr_type;
endpackage
`default_nettype wire

// ===== hdl/acpc_serial_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "acpc_regs.svh"
module acpc_serial_port
  import acpc_pkg::*;
#(
  parameter int RES_BITS  = `ACPC_RES_BITS,
  parameter int WORD_BITS = `ACPC_WORD_BITS
)(
  input  wire logic                 sck,        // Host serial clock.
  input  wire logic                 rst_n,      // Reset, active low.
  input  wire logic                 sel_conv,   // Frame: low enables port.
  input  wire logic                 sdi,        // Serial data in.
  input  wire logic [RES_BITS-1:0]  result,     // Held result word.
  output logic                      shifting,   // Past first falling edge.
  output logic                      sdo_shift,  // Shifted result bit.
  output logic [WORD_BITS-1:0]      word,       // Last complete input word.
  output logic                      word_tog    // Toggles per new word.
);
  localparam int OCW = $clog2(RES_BITS + 1);
  localparam int ICW = $clog2(WORD_BITS + 1);

  logic [OCW-1:0]       out_cnt;
  logic [ICW-1:0]       in_cnt;
  logic [WORD_BITS-2:0] in_shreg;
  logic                 frame_clr;

  // Reset clears the frame logic too, so sdo is defined before the first
  // frame has ever been opened.
  assign frame_clr = sel_conv || !rst_n;

  // ============================================================
  // Output shifter
  // The clock stands still between frames, so the frame's own level
  // clears the shifter rather than any clock edge.
  always_ff @(negedge sck or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      out_cnt   <= '0;
      shifting  <= 1'b0;
      sdo_shift <= 1'b0;
    end
    else
    begin
      shifting <= 1'b1;
      if (out_cnt < OCW'(RES_BITS - 1))
      begin
        sdo_shift <= result[RES_BITS - 2 - int'(out_cnt)];
        out_cnt   <= out_cnt + OCW'(1);
      end
      else
      begin
        sdo_shift <= 1'b0;
      end
    end
  end

  // ============================================================
  // Input word capture
  always_ff @(posedge sck or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      in_cnt   <= '0;
      in_shreg <= '0;
    end
    else if (in_cnt < ICW'(WORD_BITS))
    begin
      in_shreg <= {in_shreg[WORD_BITS-3:0], sdi};
      in_cnt   <= in_cnt + ICW'(1);
    end
  end

  // The word survives the frame end so the system side can pick it up.
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word     <= WORD_BITS'(`ACPC_WORD_RST);
      word_tog <= 1'b0;
    end
    else if (!sel_conv && in_cnt == ICW'(WORD_BITS - 1))
    begin
      word     <= {in_shreg, sdi};
      word_tog <= ~word_tog;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/acpc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "acpc_regs.svh"
module acpc_top
  import acpc_pkg::*;
#(
  parameter int RES_BITS    = `ACPC_RES_BITS,
  parameter int WORD_BITS   = `ACPC_WORD_BITS,
  parameter int WAKE_CYCLES = `ACPC_WAKE_CYCLES
)(
  input  wire logic                clk_sys,        // System clock, 20 MHz.
  input  wire logic                rst_n,          // Async reset, active low.
  input  wire logic                sel_conv,       // Select/convert pin.
  input  wire logic                sck,            // Host serial clock.
  input  wire logic                sdi,            // Serial data in.
  input  wire logic [RES_BITS-1:0] core_code,      // Offset-binary raw code.
  output logic                     sdo,            // Serial data out.
  output logic                     conv_busy,      // Conversion running.
  output logic                     core_power_on,  // Converter powered.
  output logic                     ref_power_on,   // Reference powered.
  output logic                     sleep_active,   // Sleep state.
  output logic                     wake_ready,     // Wake time elapsed.
  output logic                     acq_done,       // Acquisition time met.
  output logic                     unipolar_mode   // Current coding mode.
);
  // ============================================================
  // Timing counts
  localparam int CONV_CYCLES   = `ACPC_CYC(`ACPC_T_CONV_TYP_NS);
  localparam int CONV_MAX_CYC  = `ACPC_CYC(`ACPC_T_CONV_MAX_NS);
  localparam int ACQ_CYCLES    = (`ACPC_T_ACQ_NS * `ACPC_CLK_MHZ + 999) / 1000;
  localparam int SAMPLE_CYCLES = `ACPC_CYC(`ACPC_T_SAMPLE_NS);
  localparam int CCW = $clog2(CONV_MAX_CYC + 1);
  localparam int ACW = $clog2(ACQ_CYCLES + 1);
  localparam int WCW = $clog2(WAKE_CYCLES + 1);

  // The typical figure is used so the worst-case limit always holds, and
  // the acquisition still fits inside one sample period.
  localparam bit TIMING_OK = (CONV_CYCLES <= CONV_MAX_CYC) &&
                             (CONV_CYCLES + ACQ_CYCLES <= SAMPLE_CYCLES);

  // ============================================================
  // Signals
  acpc_pwr_type         pwr_state;
  acpc_pwr_type         next_pwr_state;
  logic                 sel_meta;
  logic                 sel_sync;
  logic                 sel_last;
  logic                 start_edge;
  logic [CCW-1:0]       conv_cnt;
  logic                 conv_end;
  logic [ACW-1:0]       acq_cnt;
  logic [RES_BITS-1:0]  result;
  logic [RES_BITS-1:0]  coded_result;
  logic                 result_msb;
  logic                 sleep_req;
  logic                 tog_meta;
  logic                 tog_sync;
  logic                 tog_last;
  logic                 word_new;
  logic [WCW-1:0]       wake_cnt;
  logic                 port_shifting;
  logic                 port_sdo;
  logic [WORD_BITS-1:0] port_word;
  logic                 port_word_tog;

  // ============================================================
  // Result coding
  // The core delivers offset binary; flipping the MSB gives two's
  // complement, while unipolar codes pass unchanged.
  function automatic logic [RES_BITS-1:0] code_result(
    input logic [RES_BITS-1:0] raw,
    input logic                uni
  );
    code_result = uni ? raw : {~raw[RES_BITS-1], raw[RES_BITS-2:0]};
  endfunction

  // ============================================================
  // Pin synchronisers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_meta <= 1'b0;
      sel_sync <= 1'b0;
      sel_last <= 1'b0;
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      tog_last <= 1'b0;
    end
    else
    begin
      sel_meta <= sel_conv;
      sel_sync <= sel_meta;
      sel_last <= sel_sync;
      tog_meta <= port_word_tog;
      tog_sync <= tog_meta;
      tog_last <= tog_sync;
    end
  end

  assign start_edge = sel_sync && !sel_last;
  assign coded_result = code_result(core_code, unipolar_mode);
  assign word_new   = tog_sync != tog_last;
  assign conv_end   = (pwr_state == PWR_CONV) &&
                      (conv_cnt == CCW'(CONV_CYCLES - 1));

  // ============================================================
  // Configuration from the serial word
  // The word is only sampled after its toggle has crossed, by which time
  // the serial side has stopped changing it.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_req     <= 1'b0;
      unipolar_mode <= 1'b0;
    end
    else if (word_new)
    begin
      sleep_req     <= port_word[`ACPC_SLEEP_BIT];
      unipolar_mode <= port_word[`ACPC_UNIPOLAR_BIT];
    end
  end

  // ============================================================
  // Power and conversion sequencer
  always_comb
  begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      PWR_ON:
      begin
        if (sleep_req)
          next_pwr_state = PWR_SLEEP;
        else if (start_edge)
          next_pwr_state = PWR_CONV;
      end
      PWR_NAP:
      begin
        if (sleep_req)
          next_pwr_state = PWR_SLEEP;
        else if (start_edge)
          next_pwr_state = PWR_CONV;
        else if (!sel_sync)
          next_pwr_state = PWR_ON;
      end
      PWR_CONV:
      begin
        // Start edges fall through here untouched while busy.
        if (conv_end)
        begin
          if (sleep_req)
            next_pwr_state = PWR_SLEEP;
          else if (sel_sync)
            next_pwr_state = PWR_NAP;
          else
            next_pwr_state = PWR_ON;
        end
      end
      PWR_SLEEP:
      begin
        if (!sleep_req)
          next_pwr_state = PWR_ON;
      end
      default:
        next_pwr_state = PWR_ON;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr_state     <= PWR_ON;
      conv_busy     <= 1'b0;
      core_power_on <= 1'b1;
      ref_power_on  <= 1'b1;
      sleep_active  <= 1'b0;
    end
    else
    begin
      pwr_state     <= next_pwr_state;
      conv_busy     <= next_pwr_state == PWR_CONV;
      core_power_on <= next_pwr_state == PWR_ON ||
                       next_pwr_state == PWR_CONV;
      ref_power_on  <= next_pwr_state != PWR_SLEEP;
      sleep_active  <= next_pwr_state == PWR_SLEEP;
    end
  end

  // ============================================================
  // Conversion timer and acquisition timer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      conv_cnt <= '0;
    else if (pwr_state != PWR_CONV || conv_end)
      conv_cnt <= '0;
    else
      conv_cnt <= conv_cnt + CCW'(1);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acq_cnt  <= '0;
      acq_done <= 1'b1;
    end
    else if (pwr_state == PWR_CONV)
    begin
      acq_cnt  <= '0;
      acq_done <= 1'b0;
    end
    else if (acq_cnt < ACW'(ACQ_CYCLES))
    begin
      acq_cnt  <= acq_cnt + ACW'(1);
      acq_done <= (acq_cnt == ACW'(ACQ_CYCLES - 1)) && TIMING_OK;
    end
  end

  // ============================================================
  // Result capture
  // The result only changes at a conversion end, and a conversion can
  // only begin once the frame is over, so the serial side reads it stable.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result     <= RES_BITS'(`ACPC_RESULT_RST);
      result_msb <= 1'b0;
    end
    else if (conv_end)
    begin
      result     <= coded_result;
      result_msb <= coded_result[RES_BITS-1];
    end
  end

  // ============================================================
  // Wake timer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_cnt   <= '0;
      wake_ready <= 1'b1;
    end
    else if (pwr_state == PWR_SLEEP)
    begin
      wake_cnt   <= WCW'(WAKE_CYCLES);
      wake_ready <= 1'b0;
    end
    else if (wake_cnt != '0)
    begin
      wake_cnt   <= wake_cnt - WCW'(1);
      wake_ready <= wake_cnt == WCW'(1);
    end
  end

  // ============================================================
  // Serial port on the host clock
  acpc_serial_port #(
    .RES_BITS  (RES_BITS),
    .WORD_BITS (WORD_BITS)
  ) u_port (
    .sck       (sck),
    .rst_n     (rst_n),
    .sel_conv  (sel_conv),
    .sdi       (sdi),
    .result    (result),
    .shifting  (port_shifting),
    .sdo_shift (port_sdo),
    .word      (port_word),
    .word_tog  (port_word_tog)
  );

  // The MSB has to be on the pin before the host's first clock edge, so
  // it comes from the system side until the shifter has taken over.
  assign sdo = port_shifting ? port_sdo : result_msb;
endmodule
`default_nettype wire

// ===== tb/acpc_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Checker
module acpc_top_asserts
#(
  parameter int RES_BITS    = 16,
  parameter int WORD_BITS   = 7,
  parameter int WAKE_CYCLES = 50
)(
  input wire logic                clk_sys,       // Clock.
  input wire logic                rst_n,         // Reset.
  input wire logic                sel_conv,      // Select pin.
  input wire logic                sck,           // Serial clock.
  input wire logic                sdi,           // Serial in.
  input wire logic [RES_BITS-1:0] core_code,     // Raw code.
  input wire logic                sdo,           // Serial out.
  input wire logic                conv_busy,     // Converting.
  input wire logic                core_power_on, // Core power.
  input wire logic                ref_power_on,  // Ref power.
  input wire logic                sleep_active,  // Sleep.
  input wire logic                wake_ready,    // Wake done.
  input wire logic                acq_done,      // Acq done.
  input wire logic                unipolar_mode  // Coding.
);
  int busy_cnt;
  int low_cnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      busy_cnt <= 0;
    else
      busy_cnt <= conv_busy ? busy_cnt + 1 : 0;

  // Low time is counted so the long wake wait needs no repetition; the
  // sleep itself is left out because the wake time starts at release.
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      low_cnt <= 0;
    else
      low_cnt <= (wake_ready || sleep_active) ? 0 : low_cnt + 1;

  a_start_resp: assert property ($rose(sel_conv) && !conv_busy
    && !sleep_active |-> ##[1:4] conv_busy) else $error("no start");
  a_conv_bound: assert property (conv_busy |-> busy_cnt < 70)
    else $error("conversion too long");
  a_conv_min: assert property ($fell(conv_busy) |-> busy_cnt >= 50)
    else $error("conversion too short");
  a_nap_entry: assert property ($fell(conv_busy) && sel_conv
    && $past(sel_conv, 4) && !sleep_active |-> !core_power_on
    && ref_power_on) else $error("no nap");
  a_stay_on: assert property ($fell(conv_busy) && !sel_conv
    && !$past(sel_conv, 4) |-> core_power_on && sdo == (unipolar_mode ?
    core_code[RES_BITS-1] : !core_code[RES_BITS-1])) else $error("msb");
  a_sleep_power: assert property (sleep_active |->
    !core_power_on && !ref_power_on) else $error("sleep power");
  a_ref_kept: assert property (!sleep_active |-> ref_power_on)
    else $error("ref off");
  a_busy_power: assert property (conv_busy |-> core_power_on)
    else $error("core off");
  a_wake_len: assert property ($rose(wake_ready) |->
    low_cnt >= WAKE_CYCLES - 2 && low_cnt <= WAKE_CYCLES + 2)
    else $error("wake time");
endmodule

bind acpc_top acpc_top_asserts #(.RES_BITS(RES_BITS),
  .WORD_BITS(WORD_BITS), .WAKE_CYCLES(WAKE_CYCLES)) i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .sel_conv(sel_conv), .sck(sck),
  .sdi(sdi), .core_code(core_code), .sdo(sdo), .conv_busy(conv_busy),
  .core_power_on(core_power_on), .ref_power_on(ref_power_on),
  .sleep_active(sleep_active), .wake_ready(wake_ready),
  .acq_done(acq_done), .unipolar_mode(unipolar_mode));
`default_nettype wire

// ===== tb/acpc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Host model
module acpc_host_model (
  input  wire logic clk_sys,  // Bench clock.
  input  wire logic sdo,      // Result bit.
  output logic      sel_conv, // Select/convert.
  output logic      sck,      // Serial clock.
  output logic      sdi       // Serial data.
);
  initial
  begin
    sel_conv = 1'b0;
    sck = 1'b0;
    sdi = 1'b0;
  end

  // A zero hold leaves the pin high so the device naps. A pin still high
  // from a nap is lowered first, since only a rising edge starts work.
  task automatic conv(input int hi);
    if (sel_conv)
    begin
      @(posedge clk_sys);
      sel_conv <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    sel_conv <= 1'b1;
    if (hi > 0)
    begin
      repeat (hi) @(posedge clk_sys);
      sel_conv <= 1'b0;
    end
  endtask

  // The serial clock stands still outside frames; the frame end restarts.
  task automatic frame(input logic [6:0] w, output logic [15:0] d);
    @(posedge clk_sys);
    sel_conv <= 1'b0;
    #213;
    for (int i = 0; i < 16; i++)
    begin
      sdi <= (i < 7) ? w[6-i] : ~sdi;
      #62.5 sck = 1'b1;
      d[15-i] = sdo;
      #62.5 sck = 1'b0;
    end
    sdi <= ~sdi;
    @(posedge clk_sys);
    sel_conv <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== tb/adc_conversion_power_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_power_control_tb;
  localparam int WAKE = 50;
  logic        clk_sys = 1'b0;
  logic        rst_n;
  logic [15:0] core_code;
  wire logic   sel_conv, sck, sdi, sdo, conv_busy, core_power_on;
  wire logic   ref_power_on, sleep_active, wake_ready, acq_done;
  wire logic   unipolar_mode;
  int          err_total = 0;
  int          check_count = 0;
  logic [15:0] d;
  int          len;

  always #25 clk_sys = ~clk_sys;

  acpc_top #(.WAKE_CYCLES(WAKE)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .sel_conv(sel_conv), .sck(sck), .sdi(sdi), .core_code(core_code),
    .sdo(sdo), .conv_busy(conv_busy), .core_power_on(core_power_on),
    .ref_power_on(ref_power_on), .sleep_active(sleep_active),
    .wake_ready(wake_ready), .acq_done(acq_done),
    .unipolar_mode(unipolar_mode));
  acpc_host_model i_host (.clk_sys(clk_sys), .sdo(sdo),
    .sel_conv(sel_conv), .sck(sck), .sdi(sdi));

  // ==========
  // Helpers
  task automatic ck(input logic [15:0] got, exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask

  task automatic run_conv();
    int n;
    n = 0;
    len = 0;
    while (conv_busy !== 1'b1 && n < 8)
    begin
      @(negedge clk_sys);
      n++;
    end
    while (conv_busy === 1'b1 && len < 100)
    begin
      @(negedge clk_sys);
      len++;
    end
    ck(16'(len >= 50 && len <= 70), 16'h1, "conversion time");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========
  // Scenarios
  task automatic t_nap();
    i_host.conv(0);
    run_conv();
    ck({core_power_on, ref_power_on}, 16'h1, "nap power");
    $display("test nap done");
  endtask

  task automatic t_coding();
    i_host.frame(7'h02, d);
    ck(d, 16'h9234, "bipolar result");
    ck(unipolar_mode, 16'h1, "mode");
    run_conv();
    i_host.frame(7'h00, d);
    ck(d, 16'h1234, "unipolar result");
    run_conv();
    $display("test coding done");
  endtask

  // A second start inside the conversion must not stretch it.
  task automatic t_restart();
    @(posedge clk_sys);
    core_code <= 16'h7ABC;
    i_host.conv(1);
    fork
      run_conv();
      begin
        repeat (20) @(posedge clk_sys);
        i_host.conv(1);
      end
    join
    ck({core_power_on, sdo}, 16'h3, "powered msb");
    i_host.frame(7'h00, d);
    ck(d, 16'hFABC, "short pulse result");
    run_conv();
    $display("test restart done");
  endtask

  task automatic t_rate();
    for (int i = 0; i < 3; i++)
    begin
      repeat (30) @(negedge clk_sys);
      ck(acq_done, 16'h1, "acquisition");
      i_host.conv(1);
      run_conv();
      ck(acq_done, 16'h0, "acquisition restart");
    end
    $display("test rate done");
  endtask

  task automatic t_sleep();
    int n;
    i_host.frame(7'h01, d);
    repeat (10) @(negedge clk_sys);
    ck({sleep_active, core_power_on, ref_power_on, conv_busy}, 16'h8,
       "sleep state");
    n = 0;
    fork
      i_host.frame(7'h00, d);
      for (int i = 0; i < 200; i++)
      begin
        @(negedge clk_sys);
        n += int'(wake_ready === 1'b0 && sleep_active === 1'b0);
      end
    join
    ck(16'(n >= WAKE - 2 && n <= WAKE + 2), 16'h1, "wake time");
    $display("test sleep done");
  endtask

  initial
  begin
    #400000;
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    rst_n = 1'b0;
    core_code = 16'h1234;
    repeat (5) @(negedge clk_sys);
    ck({sdo, conv_busy, core_power_on, ref_power_on, sleep_active,
        wake_ready, acq_done, unipolar_mode}, 16'h36, "reset values");
    repeat (7) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk_sys);
    ck({conv_busy, core_power_on, sleep_active}, 16'h2, "after reset");
    t_nap();
    t_coding();
    t_restart();
    t_rate();
    t_sleep();
    tally_and_finish();
  end
endmodule
`default_nettype wire
